// *** scd_checker.sv ***
`timescale 1ns/1ps
module scd_checker
    import scd_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // Settings from the user end
    input wire logic run,
    input wire logic src_ext,
    input wire logic lock_en,
    input wire logic [2:0] m_ai,
    input wire logic [2:0] m_ao,
    input wire logic [4:0] m_out,
    input wire logic [1:0] interp,
    // Status and ticks from the adapter end
    input wire logic running,
    input wire logic cfg_err,
    input wire logic locked,
    input wire logic ai_tick,
    input wire logic ao_tick
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    // All settings except run and lock_en as one word
    wire [13:0] cfg = {src_ext, m_ai, m_ao, m_out, interp};
    // Legal divider and interpolation mix
    logic ok;
    always_comb begin
        ok = m_ai <= M_DOM_MAX && m_ao <= M_DOM_MAX && m_out <= M_OUT_MAX
            && (6'h01 << interp) <= ((m_ao == 3'h0) ? 6'h04 : {m_ao, 3'h0});
    end
    // Start request on settings that have settled for a cycle
    sequence s_arm;
        !running ##1 (run && !running && $stable(cfg));
    endsequence
    chk_run_start: assert property (s_arm ##0 ok |=> running)
        else $error("run with legal settings did not start");
    chk_bad_cfg: assert property (s_arm ##0 !ok |=> cfg_err && !running)
        else $error("illegal settings were not refused");
    chk_err_clears: assert property ($rose(cfg_err) |=> !run)
        else $error("run not dropped after refusal");
    chk_cfg_frozen: assert property (running |=> $stable(cfg))
        else $error("settings changed while running");
    chk_stop_ack: assert property (!run && running |=> !running)
        else $error("stop not taken next edge");
    chk_idle_quiet: assert property (!running ##1 !running |-> !ai_tick && !ao_tick)
        else $error("tick while stopped");
    chk_lock_drop: assert property ((src_ext || !lock_en)[*2] |-> !locked)
        else $error("locked without internal source and lock enable");
    chk_tick_pair: assert property (running && m_ai == m_ao |-> ai_tick == ao_tick)
        else $error("equal dividers gave unequal ticks");
    chk_ai_div: assert property (ai_tick && m_ai != 3'h0 |=> !ai_tick)
        else $error("input tick faster than divider");
    chk_ao_div: assert property (ao_tick && m_ao != 3'h0 |=> !ao_tick)
        else $error("output tick faster than divider");
endmodule

// *** scd_dev.sv ***
// Decided for this implementation: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
// Behaviour
// - Fixed oscillator, free-running or locked to sync
// - External clock only samples, never lock reference
// - Sync reference is 10 MHz, lock use only
// - Domain dividers independent, N=1 or 2M, M<=5
// - Exported clock divider, N=1 or 2M, M<=16
// - External source clock 20-100 MHz, domain clocks divided from it
// - One input sample per input domain tick
// - Interpolation 1,2,4,8; product at most 400 MS/s
// - User supplies one output word per tick
// - Reset default: internal oscillator, interpolation four
// - Samples used only in their own domain
module scd_dev
    import scd_pkg::*;
#(
    parameter int SETTLE_CYC = LOCK_SETTLE_CYC,
    parameter int LOCK_EDGES = 8
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // Link to user logic
    scd_if.dev lnk,
    // Sample clock sources, one-cycle ticks
    input wire logic osc_tick,
    input wire logic ext_clk_tick,
    input wire logic chassis_sync_reference,
    // Converter side
    input wire logic [ADC_W-1:0] adc_ch0,
    input wire logic [ADC_W-1:0] adc_ch1,
    output logic [DAC_W-1:0] dac_ch0,
    output logic [DAC_W-1:0] dac_ch1,
    output logic [1:0] dac_interp,
    output logic clk_out
);
    initial begin
        if (SETTLE_CYC < 1 || LOCK_EDGES < 1) begin
            $error("scd_dev: bad lock parameters");
        end
    end

    // Active settings, frozen while running
    logic src_ext_q;
    logic [2:0] m_ai_q;
    logic [2:0] m_ao_q;
    logic [4:0] m_out_q;
    logic [1:0] interp_q;
    logic running_q;
    logic cfg_err_q;
    // Settings check on the requested values
    logic cfg_ok;
    logic [4:0] n_ao;
    logic [3:0] interp_f;
    // Sample clock tick after source select
    logic samp_tick;
    // Divider counters
    logic [3:0] c_ai_q;
    logic [3:0] c_ao_q;
    logic [4:0] c_out_q;
    logic ai_en;
    logic ao_en;
    logic out_en;
    // Lock tracking
    logic locked_q;
    logic [7:0] gap_q;
    logic [7:0] edges_q;
    logic [$clog2(SETTLE_CYC+1)-1:0] settle_q;
    // Output stages
    logic ai_tick_q;
    logic ao_tick_q;
    logic [ADC_W-1:0] ai0_q;
    logic [ADC_W-1:0] ai1_q;
    logic [DAC_W-1:0] dac0_q;
    logic [DAC_W-1:0] dac1_q;
    logic clk_out_q;

    // Requested settings must be in range and within update ceiling
    always_comb begin
        n_ao = (lnk.m_ao == 3'h0) ? 5'h01 : {1'b0, lnk.m_ao, 1'b0};
        interp_f = 4'h1 << lnk.interp;
        cfg_ok = (lnk.m_ai <= M_DOM_MAX) && (lnk.m_ao <= M_DOM_MAX)
            && (lnk.m_out <= M_OUT_MAX)
            && ({3'h0, interp_f} <= 7'(CONV_RATIO) * {2'h0, n_ao});
    end

    // Settings taken only while stopped; refused run flags an error
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            src_ext_q <= 1'b0;
            m_ai_q <= M_RST;
            m_ao_q <= M_RST;
            m_out_q <= 5'h00;
            interp_q <= INTERP_RST;
            running_q <= 1'b0;
            cfg_err_q <= 1'b0;
        end else if (!running_q) begin
            // Clocks stopped: safe to load new settings
            src_ext_q <= lnk.src_ext;
            m_ai_q <= lnk.m_ai;
            m_ao_q <= lnk.m_ao;
            m_out_q <= lnk.m_out;
            interp_q <= lnk.interp;
            cfg_err_q <= lnk.run && !cfg_ok;
            running_q <= lnk.run && cfg_ok;
        end else if (!lnk.run) begin
            // Stop request
            running_q <= 1'b0;
        end
    end

    // Source select; the external pin only ever clocks samples
    always_comb begin
        samp_tick = running_q && (src_ext_q ? ext_clk_tick : osc_tick);
    end

    // Input domain divider, counts 0 to 2M-1
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            c_ai_q <= 4'h0;
        end else if (!running_q) begin
            c_ai_q <= 4'h0;
        end else if (samp_tick) begin
            c_ai_q <= (c_ai_q + 4'h1 >= {m_ai_q, 1'b0}) ? 4'h0 : c_ai_q + 4'h1;
        end
    end

    // Output domain divider, counts 0 to 2M-1
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            c_ao_q <= 4'h0;
        end else if (!running_q) begin
            c_ao_q <= 4'h0;
        end else if (samp_tick) begin
            c_ao_q <= (c_ao_q + 4'h1 >= {m_ao_q, 1'b0}) ? 4'h0 : c_ao_q + 4'h1;
        end
    end

    // Exported clock divider, counts half periods of M ticks
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            c_out_q <= 5'h00;
        end else if (!running_q) begin
            c_out_q <= 5'h00;
        end else if (samp_tick) begin
            c_out_q <= (c_out_q + 5'h01 >= m_out_q) ? 5'h00 : c_out_q + 5'h01;
        end
    end

    // Domain enables; a 4-bit count of 2M ticks covers M up to 5
    always_comb begin
        ai_en = samp_tick && (m_ai_q == 3'h0 || c_ai_q == 4'h0);
        ao_en = samp_tick && (m_ao_q == 3'h0 || c_ao_q == 4'h0);
        out_en = samp_tick && (m_out_q == 5'h00 || c_out_q == 5'h00);
    end

    // Exported clock: toggles each M ticks, so period is 2M ticks
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            clk_out_q <= 1'b0;
        end else if (!running_q) begin
            clk_out_q <= 1'b0;
        end else if (out_en) begin
            clk_out_q <= (m_out_q == 5'h00) ? 1'b1 : !clk_out_q;
        end else if (m_out_q == 5'h00) begin
            // N = 1 gives one pulse per sample tick
            clk_out_q <= 1'b0;
        end
    end

    // Input samples: one captured per input tick
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            ai_tick_q <= 1'b0;
            ai0_q <= '0;
            ai1_q <= '0;
        end else begin
            ai_tick_q <= ai_en;
            if (ai_en) begin
                ai0_q <= adc_ch0;
                ai1_q <= adc_ch1;
            end
        end
    end

    // Output samples: word taken on each output tick
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            ao_tick_q <= 1'b0;
            dac0_q <= '0;
            dac1_q <= '0;
        end else begin
            ao_tick_q <= ao_en;
            if (ao_tick_q) begin
                dac0_q <= lnk.ao_ch0;
                dac1_q <= lnk.ao_ch1;
            end
        end
    end

    // Lock tracking of the oscillator to the sync reference
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            gap_q <= 8'h00;
            edges_q <= 8'h00;
            settle_q <= '0;
            locked_q <= 1'b0;
        end else if (!lnk.lock_en || src_ext_q) begin
            // Free-running, or external source: no lock
            gap_q <= 8'h00;
            edges_q <= 8'h00;
            settle_q <= '0;
            locked_q <= 1'b0;
        end else if (chassis_sync_reference) begin
            // Reference edge seen
            gap_q <= 8'h00;
            if (edges_q < 8'(LOCK_EDGES)) begin
                edges_q <= edges_q + 8'h01;
            end
        end else if (gap_q >= 8'(SYNC_GAP_CYC)) begin
            // Reference lost
            edges_q <= 8'h00;
            settle_q <= '0;
            locked_q <= 1'b0;
        end else begin
            gap_q <= gap_q + 8'h01;
            if (edges_q >= 8'(LOCK_EDGES)) begin
                // Loop settles slowly with narrow bandwidth
                if (settle_q >= ($clog2(SETTLE_CYC+1))'(SETTLE_CYC - 1)) begin
                    locked_q <= 1'b1;
                end else begin
                    settle_q <= settle_q + 1'b1;
                end
            end
        end
    end

    // Link outputs
    assign lnk.running = running_q;
    assign lnk.cfg_err = cfg_err_q;
    assign lnk.locked = locked_q;
    assign lnk.ai_tick = ai_tick_q;
    assign lnk.ai_ch0 = ai0_q;
    assign lnk.ai_ch1 = ai1_q;
    assign lnk.ao_tick = ao_tick_q;
    // Converter outputs
    assign dac_ch0 = dac0_q;
    assign dac_ch1 = dac1_q;
    assign dac_interp = interp_q;
    assign clk_out = clk_out_q;
endmodule

// *** scd_if.sv ***
`timescale 1ns/1ps
interface scd_if
    import scd_pkg::*;
();
    // Configuration from the user logic
    logic run;
    logic src_ext;
    logic lock_en;
    logic [2:0] m_ai;
    logic [2:0] m_ao;
    logic [4:0] m_out;
    logic [1:0] interp;
    // Status from the adapter
    logic running;
    logic cfg_err;
    logic locked;
    // Input domain
    logic ai_tick;
    logic [ADC_W-1:0] ai_ch0;
    logic [ADC_W-1:0] ai_ch1;
    // Output domain
    logic ao_tick;
    logic [DAC_W-1:0] ao_ch0;
    logic [DAC_W-1:0] ao_ch1;

    // Adapter end
    modport dev (
        input run, src_ext, lock_en, m_ai, m_ao, m_out, interp, ao_ch0, ao_ch1,
        output running, cfg_err, locked, ai_tick, ai_ch0, ai_ch1, ao_tick
    );
    // User logic end
    modport usr (
        output run, src_ext, lock_en, m_ai, m_ao, m_out, interp, ao_ch0, ao_ch1,
        input running, cfg_err, locked, ai_tick, ai_ch0, ai_ch1, ao_tick
    );
endinterface

// *** scd_pkg.sv ***
package scd_pkg;
    // Clock and timing
    localparam int REF_CLK_HZ = 25_000_000;
    localparam int REF_CLK_NS = 40;
    // Internal oscillator frequency, fixed
    localparam int OSC_FREQ_HZ = 100_000_000;
    // Lock loop bandwidth and settle time of the loop
    localparam int LOCK_BW_HZ = 200;
    localparam int LOCK_SETTLE_US = 5_000;
    localparam int LOCK_SETTLE_CYC = (LOCK_SETTLE_US * 1000) / REF_CLK_NS;
    // Sync reference is 10 MHz; a missing edge for this long drops lock
    localparam int SYNC_REF_HZ = 10_000_000;
    localparam int SYNC_GAP_NS = 400;
    localparam int SYNC_GAP_CYC = SYNC_GAP_NS / REF_CLK_NS;
    // External clock allowed range
    localparam int EXT_MIN_HZ = 20_000_000;
    localparam int EXT_MAX_HZ = 100_000_000;
    // Divider ranges, M = 0 encodes N = 1, else N = 2*M
    localparam logic [2:0] M_DOM_MAX = 3'h5;
    localparam logic [4:0] M_OUT_MAX = 5'h10;
    // Interpolation, code k means factor 2**k
    localparam logic [1:0] INTERP_X1 = 2'h0;
    localparam logic [1:0] INTERP_X4 = 2'h2;
    localparam logic [1:0] INTERP_X8 = 2'h3;
    // Converter update ceiling, as a multiple of the oscillator rate
    localparam int CONV_MAX_MSPS = 400;
    localparam int CONV_RATIO = CONV_MAX_MSPS / (OSC_FREQ_HZ / 1_000_000);
    // Sample widths
    localparam int ADC_W = 14;
    localparam int DAC_W = 16;
    // Host register map
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_DIV = 4'h4;
    localparam logic [3:0] REG_STATUS = 4'h8;
    // CTRL fields
    localparam int CTRL_RUN = 0;
    localparam int CTRL_SRC = 1;
    localparam int CTRL_LOCK = 2;
    // DIV fields
    localparam int DIV_AI_LSB = 0;
    localparam int DIV_AO_LSB = 4;
    localparam int DIV_OUT_LSB = 8;
    localparam int DIV_INT_LSB = 16;
    // STATUS fields
    localparam int ST_LOCKED = 0;
    localparam int ST_ERR = 1;
    localparam int ST_RUN = 2;
    // Reset values
    localparam logic [1:0] INTERP_RST = INTERP_X4;
    localparam logic [2:0] M_RST = 3'h0;
endpackage

// *** scd_usr.sv ***
`timescale 1ns/1ps
module scd_usr
    import scd_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // Register port
    input wire logic [3:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    // Input sample stream
    output logic ai_valid,
    output logic [ADC_W-1:0] ai_out0,
    output logic [ADC_W-1:0] ai_out1,
    // Output sample stream
    output logic ao_req,
    input wire logic [DAC_W-1:0] ao_in0,
    input wire logic [DAC_W-1:0] ao_in1,
    // Link to adapter
    scd_if.usr lnk
);
    // Control register bits
    logic run_q;
    logic src_q;
    logic lock_q;
    // Divider register fields
    logic [2:0] m_ai_q;
    logic [2:0] m_ao_q;
    logic [4:0] m_out_q;
    logic [1:0] interp_q;
    // Read data and sample registers
    logic [31:0] rdata_q;
    logic ai_valid_q;
    logic [ADC_W-1:0] ai0_q;
    logic [ADC_W-1:0] ai1_q;
    logic [DAC_W-1:0] ao0_q;
    logic [DAC_W-1:0] ao1_q;

    // Register writes; divider writes ignored while running
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            run_q <= 1'b0;
            src_q <= 1'b0;
            lock_q <= 1'b0;
            m_ai_q <= M_RST;
            m_ao_q <= M_RST;
            m_out_q <= 5'h00;
            interp_q <= INTERP_RST;
        end else if (wr) begin
            if (addr == REG_CTRL) begin
                run_q <= wdata[CTRL_RUN];
                if (!run_q && !lnk.running) begin
                    src_q <= wdata[CTRL_SRC];
                end
                lock_q <= wdata[CTRL_LOCK] && !wdata[CTRL_SRC];
            end else if (addr == REG_DIV && !run_q && !lnk.running) begin
                m_ai_q <= wdata[DIV_AI_LSB +: 3];
                m_ao_q <= wdata[DIV_AO_LSB +: 3];
                m_out_q <= wdata[DIV_OUT_LSB +: 5];
                interp_q <= wdata[DIV_INT_LSB +: 2];
            end
        end else if (run_q && lnk.cfg_err) begin
            // Adapter refused the settings
            run_q <= 1'b0;
        end
    end

    // Register reads, data in the following cycle
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rdata_q <= 32'h0000_0000;
        end else if (rd) begin
            unique case (addr)
                REG_CTRL: rdata_q <= {29'h0, lock_q, src_q, run_q};
                REG_DIV: rdata_q <= {14'h0, interp_q, 3'h0, m_out_q, 1'b0, m_ao_q,
                    1'b0, m_ai_q};
                REG_STATUS: rdata_q <= {29'h0, lnk.running, lnk.cfg_err, lnk.locked};
                default: rdata_q <= 32'h0000_0000;
            endcase
        end
    end

    // Input samples taken in the input domain only
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            ai_valid_q <= 1'b0;
            ai0_q <= '0;
            ai1_q <= '0;
        end else begin
            ai_valid_q <= lnk.ai_tick;
            if (lnk.ai_tick) begin
                ai0_q <= lnk.ai_ch0;
                ai1_q <= lnk.ai_ch1;
            end
        end
    end

    // Output words: one per output tick, handed over on ao_req
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            ao0_q <= '0;
            ao1_q <= '0;
        end else if (lnk.ao_tick) begin
            ao0_q <= ao_in0;
            ao1_q <= ao_in1;
        end
    end

    // Outputs
    assign rdata = rdata_q;
    assign ai_valid = ai_valid_q;
    assign ai_out0 = ai0_q;
    assign ai_out1 = ai1_q;
    assign ao_req = lnk.ao_tick;
    assign lnk.run = run_q;
    assign lnk.src_ext = src_q;
    assign lnk.lock_en = lock_q;
    assign lnk.m_ai = m_ai_q;
    assign lnk.m_ao = m_ao_q;
    assign lnk.m_out = m_out_q;
    assign lnk.interp = interp_q;
    assign lnk.ao_ch0 = ao0_q;
    assign lnk.ao_ch1 = ao1_q;
endmodule

// *** tb_sample_clock_distribution.sv ***
`timescale 1ns/1ps
module tb_sample_clock_distribution
    import scd_pkg::*;
;
    // Clock, reset, register port
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [31:0] rdata;
    // Sample streams
    logic ai_valid, ao_req, clk_out, co_q;
    logic [ADC_W-1:0] ai_out0, ai_out1, adc0 = '0, adc1 = '0;
    logic [DAC_W-1:0] ao_in0 = '0, ao_in1 = '0, dac0, dac1;
    logic [1:0] dac_interp;
    // Clock sources
    logic osc_tick = 1'b0;
    logic ext_tick = 1'b0;
    logic sync_ref = 1'b0;
    logic sync_on = 1'b0;
    // Counters and monitor state
    int n_fail = 0;
    int checks_done = 0;
    int cyc = 0, last_ai, last_ao, last_co, gap_ai, gap_ao, gap_co;
    logic [ADC_W-1:0] h0 [0:1], h1 [0:1];
    // Settings table, bit 31 picks the external source
    logic [31:0] cfgs [0:8] = '{32'h6, 32'h0002_0060, 32'h0000_1100, 32'h0003_0000,
        32'h0002_0000, 32'h8000_0321, 32'h0003_1055, 32'h0001_0112, 32'h0003_0010};
    logic [31:0] d;
    bit src;

    scd_if lnk();
    scd_usr u_scd_usr (.ref_clk(ref_clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .ai_valid(ai_valid), .ai_out0(ai_out0), .ai_out1(ai_out1),
        .ao_req(ao_req), .ao_in0(ao_in0), .ao_in1(ao_in1), .lnk(lnk));
    scd_dev #(.SETTLE_CYC(20), .LOCK_EDGES(8)) u_scd_dev (.ref_clk(ref_clk), .nrst(nrst),
        .lnk(lnk), .osc_tick(osc_tick), .ext_clk_tick(ext_tick),
        .chassis_sync_reference(sync_ref), .adc_ch0(adc0), .adc_ch1(adc1), .dac_ch0(dac0),
        .dac_ch1(dac1), .dac_interp(dac_interp), .clk_out(clk_out));
    scd_checker u_chk (.ref_clk(ref_clk), .nrst(nrst), .run(lnk.run), .src_ext(lnk.src_ext),
        .lock_en(lnk.lock_en), .m_ai(lnk.m_ai), .m_ao(lnk.m_ao), .m_out(lnk.m_out),
        .interp(lnk.interp), .running(lnk.running), .cfg_err(lnk.cfg_err),
        .locked(lnk.locked), .ai_tick(lnk.ai_tick), .ao_tick(lnk.ao_tick));

    // Clock
    initial begin
        forever #(REF_CLK_NS / 2) ref_clk = ~ref_clk;
    end

    // Model of the rules
    function automatic int nof(input int m);
        return (m == 0) ? 1 : 2 * m;
    endfunction
    function automatic bit cfg_ok(input logic [31:0] v);
        return v[2:0] <= 5 && v[6:4] <= 5 && v[12:8] <= 16
            && (1 << v[17:16]) <= 4 * nof(int'(v[6:4]));
    endfunction

    // Compare and count
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    // Register write, one strobe cycle
    task automatic wr_reg(input logic [3:0] a, input logic [31:0] v);
        @(posedge ref_clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge ref_clk);
        wr <= 1'b0;
    endtask
    // Register read, data taken the cycle after the strobe
    task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp,
            input logic [31:0] msk, input string what);
        @(posedge ref_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge ref_clk);
        rd <= 1'b0;
        @(negedge ref_clk);
        cmp(rdata & msk, exp, what);
    endtask
    // Verdict
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    // Random converter words, sync pulses every third cycle
    always @(posedge ref_clk) begin
        adc0 <= ADC_W'($urandom);
        adc1 <= ADC_W'($urandom);
        sync_ref <= sync_on && (cyc % 3 == 0);
    end

    // Monitor: input words two cycles after the source tick, event spacing
    always @(negedge ref_clk) begin
        cyc++;
        if (ai_valid) begin
            cmp({4'h0, ai_out1, ai_out0}, {4'h0, h1[1], h0[1]}, "ai words");
            gap_ai = cyc - last_ai;
            last_ai = cyc;
        end
        if (ao_req) begin
            gap_ao = cyc - last_ao;
            last_ao = cyc;
        end
        if (clk_out && !co_q) begin
            gap_co = cyc - last_co;
            last_co = cyc;
        end
        co_q = clk_out;
        h0[1] = h0[0];
        h1[1] = h1[0];
        h0[0] = adc0;
        h1[0] = adc1;
    end

    // Watchdog
    initial begin
        #(REF_CLK_NS * 20000);
        n_fail++;
        test_done();
    end

    // Main sequence
    initial begin
        void'($urandom(32'h712BFFA4));
        repeat (8) @(posedge ref_clk);
        nrst <= 1'b1;
        @(negedge ref_clk);
        cmp({30'h0, dac_interp}, {30'h0, INTERP_RST}, "reset interp");
        rd_chk(REG_STATUS, 32'h0, 32'hFFFF_FFFF, "reset status");
        wr_reg(4'hC, 32'hFFFF_FFFF);
        rd_chk(4'hC, 32'h0, 32'hFFFF_FFFF, "unmapped");
        $display("test reset done");
        // Every settings word, legal and illegal
        foreach (cfgs[i]) begin
            d = cfgs[i];
            src = d[31];
            @(posedge ref_clk);
            osc_tick <= !src;
            ext_tick <= src;
            ao_in0 <= DAC_W'($urandom);
            ao_in1 <= DAC_W'($urandom);
            wr_reg(REG_CTRL, {30'h0, src, 1'b0});
            wr_reg(REG_DIV, {1'b0, d[30:0]});
            wr_reg(REG_CTRL, {30'h0, src, 1'b1});
            // Status read at once: the refusal flag stands only two cycles
            if (!cfg_ok(d)) begin
                rd_chk(REG_STATUS, 32'h2, 32'h6, "refused");
            end else begin
                rd_chk(REG_STATUS, 32'h4, 32'h4, "started");
                gap_ai = 0;
                gap_ao = 0;
                gap_co = 0;
                repeat (80) @(posedge ref_clk);
                @(negedge ref_clk);
                cmp(gap_ai, nof(int'(d[2:0])), "ai spacing");
                cmp(gap_ao, nof(int'(d[6:4])), "ao spacing");
                if (d[12:8] != 0) cmp(gap_co, nof(int'(d[12:8])), "clk out");
                cmp({30'h0, dac_interp}, {30'h0, d[17:16]}, "interp");
                cmp({dac1, dac0}, {ao_in1, ao_in0}, "dac words");
                wr_reg(REG_DIV, 32'h0);
                rd_chk(REG_DIV, d & 32'h0003_1F77, 32'hFFFF_FFFF, "frozen");
            end
            wr_reg(REG_CTRL, 32'h0);
            rd_chk(REG_STATUS, 32'h0, 32'h4, "stopped");
        end
        $display("test settings done");
        // Lock to the sync reference, lose it, then external source
        sync_on <= 1'b1;
        wr_reg(REG_CTRL, 32'h4);
        repeat (100) @(posedge ref_clk);
        rd_chk(REG_STATUS, 32'h1, 32'h1, "locked");
        sync_on <= 1'b0;
        repeat (20) @(posedge ref_clk);
        rd_chk(REG_STATUS, 32'h0, 32'h1, "lock lost");
        sync_on <= 1'b1;
        wr_reg(REG_CTRL, 32'h6);
        rd_chk(REG_CTRL, 32'h2, 32'h7, "ext no lock");
        repeat (100) @(posedge ref_clk);
        rd_chk(REG_STATUS, 32'h0, 32'h1, "ext unlocked");
        $display("test lock done");
        test_done();
    end
endmodule
